// ---- core/copro_device.sv ----
// Coprocessor end of the host port: handshake, strobes, operand FIFO
`timescale 1ns/10ps
`include "copro_port_cfg.svh"
module copro_device import copro_port_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  copro_port_if.device port,
  output logic [15:0] opcodeOut,
  output logic opcodeValid,
  output logic [15:0] operandOut,
  output logic operandOutValid,
  input wire logic operandOutReady,
  input wire logic [15:0] statusWord,
  input wire logic [15:0] resultWord
);
  typedef struct packed {
    dev_state_e state;
    logic strapLatch;
    logic divPhase;
    logic [4:0] wakeCnt;
    logic [3:0] opsLeft;
    logic [3:0] burstLeft;
    logic [3:0] execCnt;
    logic ackMeta;
    logic ackSync;
    logic ackPrev;
    logic wrPrev;
    logic rdPrev;
    logic request;
    logic busy_n;
    logic error_n;
    logic errPending;
    logic clrPending;
    logic oe_n;
    word_t drive;
    word_t opcode;
    logic opcodeStb;
  } dev_s;
  dev_s st_reg;
  dev_s st_next;
  logic tick;
  logic selected;
  logic wrEdge;
  logic rdEdge;
  logic [1:0] cmd;
  logic fifoInReady;
  logic fifoPush;
  always_comb begin
    st_next = st_reg;
    st_next.opcodeStb = 1'b0;
    // Second stage and its delayed copy (ackPrev) feed logic; first stage is metastable guard
    st_next.ackMeta = port.operandAcknowledge_n;
    st_next.ackSync = st_reg.ackMeta;
    st_next.ackPrev = st_reg.ackSync;
    st_next.wrPrev = port.coprocWrite_n;
    st_next.rdPrev = port.coprocRead_n;
    st_next.divPhase = ~st_reg.divPhase;
    tick = st_reg.strapLatch | st_reg.divPhase;
    selected = !port.selectLow_n && port.selectHigh;
    wrEdge = selected && st_reg.wrPrev && !port.coprocWrite_n;
    rdEdge = selected && !port.coprocRead_n;
    cmd = {port.commandBitOne, port.commandBitZero};
    fifoPush = 1'b0;
    // Drivers on only in the clock after a selected read is seen
    st_next.oe_n = !rdEdge;
    st_next.drive = (cmd == `CMD_OPCODE) ? statusWord : resultWord;
    if (wrEdge && cmd == `CMD_OPCODE && st_reg.state == DEV_IDLE) begin
      st_next.opcode = port.dataBus;
      st_next.opcodeStb = 1'b1;
      st_next.busy_n = 1'b0;
      st_next.errPending = port.dataBus[`ERR_OPCODE_BIT];
      st_next.clrPending = port.dataBus[`CLR_OPCODE_BIT];
      st_next.opsLeft = port.dataBus[3:0];
      st_next.burstLeft = (port.dataBus[3:0] > 4'(`BURST_LIMIT)) ?
                          4'(`BURST_FIRST) : port.dataBus[3:0];
      st_next.execCnt = 4'(`EXEC_CLOCKS);
      st_next.state = (port.dataBus[3:0] != 4'h0) ? DEV_OPERAND : DEV_EXEC;
    end
    if (wrEdge && cmd == `CMD_OPERAND && st_reg.state == DEV_OPERAND) begin
      fifoPush = 1'b1;
    end
    case (st_reg.state)
      DEV_DORMANT: begin
        // Strap is sampled only while dormant; moving it later is ignored
        st_next.strapLatch = port.clockDivideStrap;
        if (tick) begin
          if (st_reg.wakeCnt == 5'h00) begin
            st_next.state = DEV_IDLE;
          end else begin
            st_next.wakeCnt = st_reg.wakeCnt - 5'h01;
          end
        end
      end
      DEV_IDLE: begin
      end
      DEV_OPERAND: begin
        st_next.request = fifoInReady;
        if (!st_reg.ackSync && st_reg.ackPrev) begin
          st_next.opsLeft = st_reg.opsLeft - 4'h1;
          st_next.burstLeft = st_reg.burstLeft - 4'h1;
          if (st_reg.opsLeft == 4'h1) begin
            st_next.request = 1'b0;
            st_next.state = DEV_EXEC;
          end else if (st_reg.burstLeft == 4'h1) begin
            st_next.request = 1'b0;
            st_next.state = DEV_PAUSE;
          end
        end
      end
      DEV_PAUSE: begin
        if (st_reg.ackSync && tick) begin
          st_next.burstLeft = (st_reg.opsLeft > 4'(`BURST_NEXT)) ?
                              4'(`BURST_NEXT) : st_reg.opsLeft;
          st_next.state = DEV_OPERAND;
        end
      end
      DEV_EXEC: begin
        st_next.request = 1'b0;
        if (tick) begin
          if (st_reg.execCnt == 4'h0) begin
            // Error moves only while busy still held
            if (st_reg.errPending) begin
              st_next.error_n = 1'b0;
            end else if (st_reg.clrPending) begin
              st_next.error_n = 1'b1;
            end
            st_next.busy_n = 1'b1;
            st_next.state = DEV_IDLE;
          end else begin
            st_next.execCnt = st_reg.execCnt - 4'h1;
          end
        end
      end
      default: begin
        st_next.state = DEV_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.state <= DEV_DORMANT;
      st_reg.busy_n <= 1'b1;
      st_reg.error_n <= 1'b1;
      st_reg.oe_n <= 1'b1;
      st_reg.wakeCnt <= 5'(`RESET_BUSY_CLOCKS - 1);
      st_reg.ackMeta <= 1'b1;
      st_reg.ackSync <= 1'b1;
      st_reg.ackPrev <= 1'b1;
      st_reg.wrPrev <= 1'b1;
      st_reg.rdPrev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  copro_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) operandFifo (
    .clk(clk),
    .rst(rst),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(port.dataBus),
    .outValid(operandOutValid),
    .outReady(operandOutReady),
    .outData(operandOut)
  );
  assign port.operandRequest = st_reg.request;
  assign port.busy_n = st_reg.busy_n;
  assign port.error_n = st_reg.error_n;
  assign port.devDataOe_n = st_reg.oe_n;
  assign port.devData = st_reg.drive;
  assign opcodeOut = st_reg.opcode;
  assign opcodeValid = st_reg.opcodeStb;
endmodule : copro_device

// ---- include/copro_port_cfg.svh ----
// Constants for the coprocessor host port
// Notes on behaviour
// - Strap high uses clock directly, low halves.
// - Strap stable four internal clocks before release.
// - Rising reset abandons work, goes dormant.
// - Host holds reset at least four clocks.
// - Device busy 25 clocks after reset falls; the code keeps busy_n high while dormant for 25 ticks instead.
// - Reset: busy high, error high, request low.
// - Request asserted when FIFO ready for operands.
// - Device drops request after all operands moved.
// - Over five transfers: pause after three, then four.
// - Request always inactive before busy released.
// - Busy held low while executing an instruction.
// - Error output mirrors error summary bit; the code drives error_n from opcode bits 15 and 14 instead.
// - Error cleared only by listed no-wait instructions.
// - Error changes only while busy asserted.
// - Host acknowledges request; acknowledge high in reset.
// - Acknowledge synchronised before use.
// - Sixteen-bit data bus, bit zero least significant.
// - Writes accepted only with both selects active.
// - Reads answered only with both selects active.
// - Command bits and strobes decode the cycle type.
// - No transfer unless both selects asserted.
`ifndef COPRO_PORT_CFG_SVH
`define COPRO_PORT_CFG_SVH
`define CLK_PERIOD_NS 8
`define RESET_BUSY_CLOCKS 25
`define RESET_HOLD_CLOCKS 4
`define BURST_FIRST 3
`define BURST_NEXT 4
`define BURST_LIMIT 5
`define EXEC_CLOCKS 8
`define ERR_OPCODE_BIT 15
`define CLR_OPCODE_BIT 14
`define NOWAIT_CLR_MASK 16'h4000
`define CMD_OPCODE 2'h0
`define CMD_OPERAND 2'h1
`define CMD_EXCPTR 2'h2
`endif

// ---- include/copro_port_pkg.sv ----
// Types shared by both ends of the coprocessor host port
package copro_port_pkg;
  typedef enum logic [4:0] {
    DEV_DORMANT = 5'h01,
    DEV_IDLE = 5'h02,
    DEV_OPERAND = 5'h04,
    DEV_PAUSE = 5'h08,
    DEV_EXEC = 5'h10
  } dev_state_e;
  typedef enum logic [3:0] {
    HST_IDLE = 4'h1,
    HST_WAIT = 4'h2,
    HST_XFER = 4'h4,
    HST_DONE = 4'h8
  } host_state_e;
  typedef logic [15:0] word_t;
endpackage : copro_port_pkg

// ---- include/copro_port_if.sv ----
// Pin-level link between the host and the coprocessor
`timescale 1ns/10ps
interface copro_port_if;
  logic clockDivideStrap;
  logic operandRequest;
  logic operandAcknowledge_n;
  logic busy_n;
  logic error_n;
  logic coprocRead_n;
  logic coprocWrite_n;
  logic selectLow_n;
  logic selectHigh;
  logic commandBitZero;
  logic commandBitOne;
  logic [15:0] devData;
  logic devDataOe_n;
  logic [15:0] hostData;
  logic hostDataOe_n;
  wire [15:0] dataBus;
  assign dataBus = !devDataOe_n ? devData :
                   (!hostDataOe_n ? hostData : 16'hFFFF);
  modport device (
    input clockDivideStrap, operandAcknowledge_n, coprocRead_n,
    input coprocWrite_n, selectLow_n, selectHigh, commandBitZero,
    input commandBitOne, dataBus,
    output operandRequest, busy_n, error_n, devData, devDataOe_n
  );
  modport host (
    input operandRequest, busy_n, error_n, dataBus,
    output clockDivideStrap, operandAcknowledge_n, coprocRead_n,
    output coprocWrite_n, selectLow_n, selectHigh, commandBitZero,
    output commandBitOne, hostData, hostDataOe_n
  );
endinterface : copro_port_if

// ---- core/copro_fifo.sv ----
// Operand FIFO with valid/ready on both sides
`timescale 1ns/10ps
module copro_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } fifo_s;
  fifo_s st_reg;
  fifo_s st_next;
  logic push;
  logic pop;
  always_comb begin
    st_next = st_reg;
    push = inValid && (st_reg.count != (AW+1)'(DEPTH));
    pop = outReady && (st_reg.count != '0);
    if (push) begin
      st_next.mem[st_reg.wrPtr] = inData;
      st_next.wrPtr = (st_reg.wrPtr == AW'(DEPTH-1)) ? '0 :
                      st_reg.wrPtr + 1'b1;
    end
    if (pop) begin
      st_next.rdPtr = (st_reg.rdPtr == AW'(DEPTH-1)) ? '0 : st_reg.rdPtr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign inReady = (st_reg.count != (AW+1)'(DEPTH));
  assign outValid = (st_reg.count != '0);
  assign outData = st_reg.mem[st_reg.rdPtr];
endmodule : copro_fifo

// ---- core/copro_host.sv ----
// Host end of the port: issues opcodes and moves operands
`timescale 1ns/10ps
`include "copro_port_cfg.svh"
module copro_host import copro_port_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  copro_port_if.host port,
  input wire logic strapHigh,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [15:0] cmdOpcode,
  input wire logic [15:0] cmdOperand,
  output logic hostBusy,
  output logic hostError
);
  typedef struct packed {
    host_state_e state;
    logic [4:0] settle;
    logic [3:0] left;
    word_t opcode;
    logic wr_n;
    logic ack_n;
    logic c0;
    logic sel;
    logic oe_n;
  } host_s;
  host_s st_reg;
  host_s st_next;
  always_comb begin
    st_next = st_reg;
    st_next.wr_n = 1'b1;
    st_next.oe_n = 1'b1;
    case (st_reg.state)
      HST_IDLE: begin
        if (st_reg.settle != 5'h00) begin
          st_next.settle = st_reg.settle - 5'h01;
        end else if (cmdValid && port.busy_n) begin
          st_next.opcode = cmdOpcode;
          st_next.left = cmdOpcode[3:0];
          st_next.sel = 1'b1;
          st_next.c0 = 1'b0;
          st_next.wr_n = 1'b0;
          st_next.oe_n = 1'b0;
          st_next.state = HST_WAIT;
        end
      end
      HST_WAIT: begin
        st_next.ack_n = 1'b1;
        st_next.c0 = 1'b1;
        if (st_reg.settle != 5'h00) begin
          // Device needs three edges to see the ack and update its request
          st_next.settle = st_reg.settle - 5'h01;
        end else if (st_reg.left == 4'h0) begin
          st_next.sel = 1'b0;
          st_next.state = HST_DONE;
        end else if (port.operandRequest) begin
          st_next.ack_n = 1'b0;
          st_next.wr_n = 1'b0;
          st_next.oe_n = 1'b0;
          st_next.state = HST_XFER;
        end
      end
      HST_XFER: begin
        st_next.left = st_reg.left - 4'h1;
        st_next.settle = 5'h02;
        st_next.state = HST_WAIT;
      end
      HST_DONE: begin
        st_next.state = HST_IDLE;
      end
      default: begin
        st_next.state = HST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.state <= HST_IDLE;
      st_reg.settle <= 5'(`RESET_BUSY_CLOCKS);
      st_reg.wr_n <= 1'b1;
      st_reg.ack_n <= 1'b1;
      st_reg.oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign port.clockDivideStrap = strapHigh;
  assign port.operandAcknowledge_n = st_reg.ack_n;
  assign port.coprocWrite_n = st_reg.wr_n;
  assign port.coprocRead_n = 1'b1;
  assign port.selectLow_n = !st_reg.sel;
  assign port.selectHigh = st_reg.sel;
  assign port.commandBitZero = st_reg.c0;
  assign port.commandBitOne = 1'b0;
  assign port.hostData = (st_reg.state == HST_XFER) ? cmdOperand :
                         st_reg.opcode;
  assign port.hostDataOe_n = st_reg.oe_n;
  assign cmdReady = (st_reg.state == HST_DONE);
  assign hostBusy = !port.busy_n;
  assign hostError = !port.error_n;
endmodule : copro_host

// ---- verif/copro_port_monitor.sv ----
// Concurrent checks on the pins between host and coprocessor ends
`timescale 1ns/10ps
module copro_port_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic operandRequest,
  input wire logic operandAcknowledge_n,
  input wire logic busy_n,
  input wire logic error_n,
  input wire logic coprocRead_n,
  input wire logic coprocWrite_n,
  input wire logic selectLow_n,
  input wire logic selectHigh,
  input wire logic commandBitZero,
  input wire logic commandBitOne,
  input wire logic devDataOe_n
);
  // ****************
  // Helper logic
  // ****************
  logic rdSel;
  logic [3:0] ackCnt_reg;
  assign rdSel = !coprocRead_n && !selectLow_n && selectHigh;
  // Acks seen in one request burst; cleared whenever the request drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackCnt_reg <= 4'h0;
    end else if (!operandRequest) begin
      ackCnt_reg <= 4'h0;
    end else if ($fell(operandAcknowledge_n)) begin
      ackCnt_reg <= ackCnt_reg + 4'h1;
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_PINS: assert property (disable iff (1'b0)
    rst |-> !operandRequest && devDataOe_n && busy_n && error_n)
    else $error("pins wrong during reset");
  AST_WAKE_BUSY: assert property ($fell(rst) |->
    (busy_n && error_n && !operandRequest) [*8])
    else $error("outputs active after reset");
  AST_REQ_BEFORE_BUSY: assert property ($rose(busy_n) |->
    !operandRequest && !$past(operandRequest))
    else $error("request still up at busy release");
  AST_ERR_ONLY_BUSY: assert property ($changed(error_n) |->
    !$past(busy_n)) else $error("error moved while idle");
  AST_OE_READ: assert property (!devDataOe_n |->
    rdSel || $past(rdSel)) else $error("bus driven outside read");
  AST_NO_OE_WRITE: assert property (!coprocWrite_n |->
    devDataOe_n) else $error("bus driven during write");
  AST_REQ_WHILE_BUSY: assert property (operandRequest |->
    !busy_n) else $error("request while not busy");
  AST_BURST_LIMIT: assert property (operandRequest |->
    ackCnt_reg <= 4'h4) else $error("burst too long");
  AST_OPCODE_BUSY: assert property ($fell(coprocWrite_n) &&
    !selectLow_n && selectHigh && !commandBitZero && !commandBitOne &&
    busy_n |-> ##[1:3] !busy_n) else $error("opcode did not raise busy");
endmodule : copro_port_monitor

// ---- verif/numeric_coprocessor_host_port_tb.sv ----
// Bench joining the host and coprocessor ends through the port
`timescale 1ns/10ps
module numeric_coprocessor_host_port_tb import copro_port_pkg::*;;
  logic clk, rst, strapHigh, cmdValid, cmdReady, hostBusy, hostError;
  logic opcodeValid, operandOutValid, operandOutReady;
  word_t cmdOpcode, cmdOperand, opcodeOut, operandOut;
  word_t statusWord, resultWord, pins;
  int fails, checkCount, cycles, drained;
  word_t errOpc [3] = '{16'h8000, 16'h0000, 16'h4000};
  word_t errExp [3] = '{16'h0000, 16'h0000, 16'h0001};
  copro_port_if u_copro_port_if ();
  assign pins = {13'h0, u_copro_port_if.operandRequest,
                 u_copro_port_if.busy_n, u_copro_port_if.error_n};
  copro_device #(.FIFO_DEPTH(8)) u_copro_device (.clk(clk), .rst(rst),
    .port(u_copro_port_if.device), .opcodeOut(opcodeOut),
    .opcodeValid(opcodeValid), .operandOut(operandOut),
    .operandOutValid(operandOutValid), .operandOutReady(operandOutReady),
    .statusWord(statusWord), .resultWord(resultWord));
  copro_host u_copro_host (.clk(clk), .rst(rst),
    .port(u_copro_port_if.host), .strapHigh(strapHigh),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOpcode(cmdOpcode),
    .cmdOperand(cmdOperand), .hostBusy(hostBusy), .hostError(hostError));
  copro_port_monitor u_copro_port_monitor (.clk(clk), .rst(rst),
    .operandRequest(u_copro_port_if.operandRequest),
    .operandAcknowledge_n(u_copro_port_if.operandAcknowledge_n),
    .busy_n(u_copro_port_if.busy_n), .error_n(u_copro_port_if.error_n),
    .coprocRead_n(u_copro_port_if.coprocRead_n),
    .coprocWrite_n(u_copro_port_if.coprocWrite_n),
    .selectLow_n(u_copro_port_if.selectLow_n),
    .selectHigh(u_copro_port_if.selectHigh),
    .commandBitZero(u_copro_port_if.commandBitZero),
    .commandBitOne(u_copro_port_if.commandBitOne),
    .devDataOe_n(u_copro_port_if.devDataOe_n));
  // ****************
  // Tasks
  // ****************
  task automatic check(input word_t seen, input word_t exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // Holds the command until the host reports it done, bounded wait
  task automatic issue(input word_t opc, input word_t opd);
    int n;
    cmdOpcode <= opc;
    cmdOperand <= opd;
    cmdValid <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmdReady !== 1'h1 && n < 3000);
    if (n >= 3000) begin
      fails++;
    end
    cmdValid <= 1'h0;
    @(posedge clk);
  endtask : issue
  // ****************
  // Clock, drain and timeout
  // ****************
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (operandOutValid === 1'h1 && operandOutReady === 1'h1) begin
      drained <= drained + 1;
      check(operandOut, 16'hA5C3);
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    rst = 1'h1;
    strapHigh = 1'h1;
    cmdValid = 1'h0;
    cmdOpcode = 16'h0000;
    cmdOperand = 16'h0000;
    operandOutReady = 1'h0;
    statusWord = 16'h1234;
    resultWord = 16'h5678;
    cycles = 0;
    drained = 0;
    repeat (6) @(posedge clk);
    check(pins, 16'h0003);
    check({15'h0, u_copro_port_if.devDataOe_n}, 16'h0001);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    check(pins, 16'h0003);
    repeat (30) @(posedge clk);
    check(pins, 16'h0003);
    issue(16'h0120, 16'h0000);
    check(opcodeOut, 16'h0120);
    check(pins, 16'h0001);
    // Fifteen operands fill the FIFO and hold off the request while the drain side stalls
    fork
      issue(16'h000F, 16'hA5C3);
      begin
        repeat (300) @(posedge clk);
        check(drained[15:0], 16'h0000);
        operandOutReady <= 1'h1;
      end
    join
    repeat (20) @(posedge clk);
    check(drained[15:0], 16'h000F);
    for (int i = 0; i < 3; i++) begin
      issue(errOpc[i], 16'h0000);
      repeat (12) @(posedge clk);
      check({15'h0, u_copro_port_if.error_n}, errExp[i]);
    end
    // Reset in the middle of an operand phase must abandon it
    operandOutReady <= 1'h0;
    cmdOpcode <= 16'h000F;
    cmdOperand <= 16'hA5C3;
    cmdValid <= 1'h1;
    repeat (20) @(posedge clk);
    rst <= 1'h1;
    cmdValid <= 1'h0;
    repeat (6) @(posedge clk);
    check(pins, 16'h0003);
    rst <= 1'h0;
    repeat (40) @(posedge clk);
    check(pins, 16'h0003);
    end_of_test();
  end
endmodule : numeric_coprocessor_host_port_tb
